/* common/seq_params.svh */
/*
 * constants of the setpoint sequencer: register indices, field widths,
 * reset values, encodings and timing.
 * assumes: included once per compilation unit by bare name.
 */
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define IDX_STEP_MODE 16'h4025
`define IDX_END_ACTION 16'h402f
`define IDX_RESTART 16'h4040
`define IDX_SEG_COUNT 16'h4100
`define IDX_END_SETPOINT 16'h4101
`define IDX_STATUS 16'h4102
`define IDX_DUR_BASE 16'h4200
`define IDX_SP_BASE 16'h4300
`define IDX_TABLE_MASK 16'hff00

// ==========================================================
// field widths and reset values
`define SEL_W 8
`define MODE_RST 8'h00
`define END_RST 8'h00
`define RESTART_RST 8'h00

// ==========================================================
// encodings
`define MODE_OFF 8'h00
`define MODE_TIME 8'h01
`define MODE_STEP 8'h02
`define MODE_BOTH 8'h03
`define END_KEEP 8'h00
`define END_STOP 8'h01
`define END_STOP_ABORT 8'h02
`define END_ABORT 8'h03
`define RST_SEQ 8'h00
`define RST_SEG 8'h01
`define RST_CONT 8'h02
`define RST_NEXT 8'h03
`define RST_NONE 8'h04

// ==========================================================
// timing: one duration tick is one millisecond
`define CLK_PERIOD_NS 25
`define TICK_NS 1000000

`endif

/* common/seq_pkg.sv */
/*
 * types shared by the sequencer modules.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package seq_pkg;
	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_PAUSED,
		ST_END_HOLD,
		ST_STOPPING
	} state_e;
endpackage
`default_nettype wire

/* common/seg_if.sv */
/*
 * carrier between the sequencer core and its segment timer.
 * assumes: both ends share the control clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface seg_if #(parameter int DUR_W = 16);
	logic load;
	logic [DUR_W-1:0] load_val;
	logic en;
	logic done;
	modport ctl (output load, output load_val, output en, input done);
	modport tmr (input load, input load_val, input en, output done);
endinterface
`default_nettype wire

/* core/seg_timer.sv */
/*
 * segment duration counter: counts down millisecond ticks of the loaded time.
 * assumes: load and en come from the sequencer core on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module seg_timer import seq_pkg::*; #(
	parameter int DUR_W = 16,
	parameter int TICK_CYC = `TICK_NS / `CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	seg_if.tmr bus
);
	logic [31:0] presc_r;
	logic [DUR_W-1:0] remain_r;
	wire tick = (presc_r == 32'(TICK_CYC - 1));

	// ==========================================================
	// countdown; frozen while en is low so a paused segment keeps its time
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc_r <= 32'h0;
			remain_r <= '0;
		end else if (bus.load) begin
			presc_r <= 32'h0;
			remain_r <= bus.load_val;
		end else if (bus.en && remain_r != '0) begin
			presc_r <= tick ? 32'h0 : presc_r + 32'h1;
			if (tick) remain_r <= remain_r - 1'b1;
		end
	end

	// zero duration counts as elapsed at once
	assign bus.done = (remain_r == '0);
endmodule
`default_nettype wire

/* core/setpoint_sequencer_control.sv */
/*
 * setpoint sequencer mode control: steps through timed segments and
 * hands each segment setpoint to the motor control, under three settings.
 * assumes: APB master on REF_CLK_I; all pin inputs synchronous to it;
 * MOTOR_RUN_I high while the drive runs (low after a stop or an error).
 */
// How it works
// - the step mode field codes 0 off, 1 time, 2 trigger, 3 both, and resets to off.
// - in time mode a step advances only once the segment time has fully run out.
// - in trigger mode a step advances only on the next-step trigger, durations ignored.
// - in combined mode the trigger advances, or the time running out if no trigger came first.
// - completion action 0 keeps sending the end setpoint until an abort.
// - the restart policy applies to every stop-and-start of the motor while segments run, including after an error, but not once the sequence has completed.
// - restart policy 0 starts the selected sequence again from its first segment.
// - completion action 1 stops the motor and keeps setpoint control until an abort.
// - completion action 2 stops the motor, returns control at standstill, then needs a new start.
// - completion action 3 returns control at completion without stopping the motor.
// - restart policy 1 redoes, 2 continues, 3 skips the segment, 4 keeps running while stopped.
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module setpoint_sequencer_control import seq_pkg::*; #(
	parameter int NUM_SEG = 16,
	parameter int SP_W = 16,
	parameter int DUR_W = 16,
	parameter int TICK_CYC = `TICK_NS / `CLK_PERIOD_NS
) (
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [17:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic START_I,
	input wire logic ABORT_I,
	input wire logic NEXT_STEP_I,
	input wire logic MOTOR_RUN_I,
	input wire logic STANDSTILL_I,
	output logic [SP_W-1:0] SETPOINT_O,
	output logic SEQ_CTRL_O,
	output logic STOP_REQ_O,
	output logic [$clog2(NUM_SEG)-1:0] SEG_IDX_O
);
	localparam int SW = $clog2(NUM_SEG);

	// ==========================================================
	// configuration state
	logic [`SEL_W-1:0] step_advance_mode_select_r;
	logic [`SEL_W-1:0] completion_action_select_r;
	logic [`SEL_W-1:0] restart_policy_select_r;
	logic [SW:0] seg_count_r;
	logic [SP_W-1:0] end_sp_r;
	logic [DUR_W-1:0] dur_mem [NUM_SEG];
	logic [SP_W-1:0] sp_mem [NUM_SEG];

	state_e state_r, state_nxt;
	logic [SW-1:0] seg_r, seg_nxt;
	logic start_q_r, next_q_r, run_q_r;

	seg_if #(.DUR_W(DUR_W)) tbus ();

	seg_timer #(.DUR_W(DUR_W), .TICK_CYC(TICK_CYC)) u_timer (
		.clk_i(REF_CLK_I),
		.rst_b_i(RST_B_I),
		.bus(tbus)
	);

	// ==========================================================
	// register decode
	function automatic logic is_tbl(input logic [15:0] idx, input logic [15:0] base);
		return ((idx & `IDX_TABLE_MASK) == base) && (idx[7:0] < 8'(NUM_SEG));
	endfunction

	wire [15:0] ridx = PADDR_I[17:2];
	wire [SW-1:0] tidx = ridx[SW-1:0];
	wire hit_dur = is_tbl(ridx, `IDX_DUR_BASE);
	wire hit_sp = is_tbl(ridx, `IDX_SP_BASE);
	wire hit_mode = (ridx == `IDX_STEP_MODE);
	wire hit_end = (ridx == `IDX_END_ACTION);
	wire hit_rst = (ridx == `IDX_RESTART);
	wire hit_cnt = (ridx == `IDX_SEG_COUNT);
	wire hit_esp = (ridx == `IDX_END_SETPOINT);
	wire hit_stat = (ridx == `IDX_STATUS);
	wire mapped = hit_dur | hit_sp | hit_mode | hit_end | hit_rst | hit_cnt | hit_esp | hit_stat;
	wire setup = PSEL_I & ~PENABLE_I;
	// zero wait states, so every access phase completes at its first edge
	wire wr = PSEL_I & PENABLE_I & PWRITE_I & mapped;
	wire [31:0] status = {16'h0, 8'(seg_r), 5'h0, 3'(state_r)};
	wire [31:0] rdata =
		hit_mode ? 32'(step_advance_mode_select_r) :
		hit_end ? 32'(completion_action_select_r) :
		hit_rst ? 32'(restart_policy_select_r) :
		hit_cnt ? 32'(seg_count_r) :
		hit_esp ? 32'(end_sp_r) :
		hit_stat ? status :
		hit_dur ? 32'(dur_mem[tidx]) :
		hit_sp ? 32'(sp_mem[tidx]) : 32'h0;

	// ==========================================================
	// apb answer, captured in the setup cycle for a registered output
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PRDATA_O <= 32'h0;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PRDATA_O <= setup ? rdata : 32'h0;
			PREADY_O <= setup;
			PSLVERR_O <= setup & ~mapped;
		end
	end

	// ==========================================================
	// register writes; out-of-range selector values are stored as written
	// mode resets off
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			step_advance_mode_select_r <= `MODE_RST;
			completion_action_select_r <= `END_RST;
			restart_policy_select_r <= `RESTART_RST;
			seg_count_r <= (SW+1)'(NUM_SEG);
			end_sp_r <= '0;
		end else if (wr) begin
			if (hit_mode) step_advance_mode_select_r <= PWDATA_I[`SEL_W-1:0];
			if (hit_end) completion_action_select_r <= PWDATA_I[`SEL_W-1:0];
			if (hit_rst) restart_policy_select_r <= PWDATA_I[`SEL_W-1:0];
			if (hit_cnt) seg_count_r <= PWDATA_I[SW:0];
			if (hit_esp) end_sp_r <= PWDATA_I[SP_W-1:0];
		end
	end

	// segment table, one slot per segment
	for (genvar g = 0; g < NUM_SEG; g++) begin : g_tbl
		always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				dur_mem[g] <= '0;
				sp_mem[g] <= '0;
			end else if (wr && tidx == SW'(g)) begin
				if (hit_dur) dur_mem[g] <= PWDATA_I[DUR_W-1:0];
				if (hit_sp) sp_mem[g] <= PWDATA_I[SP_W-1:0];
			end
		end
	end

	// ==========================================================
	// mode decoding; unknown codes fall back to the safe default
	wire [`SEL_W-1:0] mode = step_advance_mode_select_r;
	wire [`SEL_W-1:0] endact = (completion_action_select_r > `END_ABORT) ?
		`END_KEEP : completion_action_select_r;
	wire [`SEL_W-1:0] rpol = (restart_policy_select_r > `RST_NONE) ?
		`RST_SEQ : restart_policy_select_r;
	wire enabled = (mode != `MODE_OFF) && (mode <= `MODE_BOTH);
	wire start_rise = START_I & ~start_q_r;
	wire trig_rise = NEXT_STEP_I & ~next_q_r;
	wire run_rise = MOTOR_RUN_I & ~run_q_r;
	wire [SW:0] last_idx = (seg_count_r == '0) ? '0 : seg_count_r - 1'b1;
	wire seg_last = ({1'b0, seg_r} >= last_idx);
	wire proc = MOTOR_RUN_I | (rpol == `RST_NONE);
	wire adv_time = ((mode == `MODE_TIME) | (mode == `MODE_BOTH)) & tbus.done;
	wire adv_trig = ((mode == `MODE_STEP) | (mode == `MODE_BOTH)) & trig_rise;
	wire advance = adv_time | adv_trig;
	wire [SW-1:0] seg_inc = seg_r + 1'b1;

	// ==========================================================
	// completion target state
	function automatic state_e done_state(input logic [`SEL_W-1:0] act);
		unique case (act)
			`END_STOP_ABORT: return ST_STOPPING;
			`END_ABORT: return ST_IDLE;
			default: return ST_END_HOLD;
		endcase
	endfunction

	// ==========================================================
	// sequencer next state; abort and disable always win
	always_comb begin
		state_nxt = state_r;
		seg_nxt = seg_r;
		tbus.load = 1'b0;
		if (ABORT_I || !enabled) begin
			state_nxt = ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start_rise) begin
						state_nxt = ST_RUN;
						seg_nxt = '0;
						tbus.load = 1'b1;
					end
				end
				ST_RUN: begin
					if (!proc) begin
						state_nxt = ST_PAUSED;
					end else if (advance && seg_last) begin
						state_nxt = done_state(endact);
					end else if (advance) begin
						seg_nxt = seg_inc;
						tbus.load = 1'b1;
					end
				end
				ST_PAUSED: begin
					if (run_rise) begin
						state_nxt = ST_RUN;
						unique case (rpol)
							`RST_SEG: tbus.load = 1'b1;
							`RST_CONT: tbus.load = 1'b0;
							`RST_NEXT: begin
								if (seg_last) begin
									state_nxt = done_state(endact);
								end else begin
									seg_nxt = seg_inc;
									tbus.load = 1'b1;
								end
							end
							default: begin
								seg_nxt = '0;
								tbus.load = 1'b1;
							end
						endcase
					end
				end
				ST_END_HOLD: state_nxt = ST_END_HOLD;
				ST_STOPPING: begin
					if (STANDSTILL_I) state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	assign tbus.load_val = dur_mem[seg_nxt];
	assign tbus.en = (state_r == ST_RUN) & proc;

	// ==========================================================
	// output decoding
	wire ctrl_nxt = (state_nxt != ST_IDLE);
	wire stop_nxt = ((state_nxt == ST_END_HOLD) & (endact == `END_STOP)) |
		(state_nxt == ST_STOPPING);
	// idle drops control without a stop
	wire [SP_W-1:0] sp_nxt =
		(state_nxt == ST_END_HOLD || state_nxt == ST_STOPPING) ? end_sp_r :
		(state_nxt == ST_IDLE) ? '0 : sp_mem[seg_nxt];

	// ==========================================================
	// state and registered outputs
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r <= ST_IDLE;
			seg_r <= '0;
			start_q_r <= 1'b0;
			next_q_r <= 1'b0;
			run_q_r <= 1'b0;
			SETPOINT_O <= '0;
			SEQ_CTRL_O <= 1'b0;
			STOP_REQ_O <= 1'b0;
			SEG_IDX_O <= '0;
		end else begin
			state_r <= state_nxt;
			seg_r <= seg_nxt;
			start_q_r <= START_I;
			next_q_r <= NEXT_STEP_I;
			run_q_r <= MOTOR_RUN_I;
			SETPOINT_O <= sp_nxt;
			SEQ_CTRL_O <= ctrl_nxt;
			STOP_REQ_O <= stop_nxt;
			SEG_IDX_O <= seg_nxt;
		end
	end
endmodule
`default_nettype wire

/* tb/seq_ctl_sva.sv */
/* port assertions for the sequencer control.
   assumes: bound to each instance of the sequencer control. */
`timescale 1ns/1ps
`default_nettype none
module seq_ctl_sva #(parameter int NUM_SEG = 16) (
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic START_I,
	input wire logic ABORT_I,
	input wire logic STANDSTILL_I,
	input wire logic SEQ_CTRL_O,
	input wire logic STOP_REQ_O,
	input wire logic [$clog2(NUM_SEG)-1:0] SEG_IDX_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	// ==========================================================
	// register bus: one-cycle answer, data only with ready
	chk_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held too long");
	chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	chk_idle_rdata: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside access");
	// ==========================================================
	// sequencer ownership
	chk_abort_release: assert property (ABORT_I |=> !SEQ_CTRL_O && !STOP_REQ_O)
		else $error("abort kept control");
	chk_start_first: assert property ($rose(SEQ_CTRL_O) |->
		$past(START_I) && !$past(START_I, 2) && SEG_IDX_O == '0)
		else $error("control taken without start edge");
	chk_stop_hold: assert property (STOP_REQ_O && !ABORT_I && !STANDSTILL_I |=> STOP_REQ_O)
		else $error("stop dropped early");
	chk_stop_owns: assert property (STOP_REQ_O |-> SEQ_CTRL_O)
		else $error("stop without control");
endmodule
bind setpoint_sequencer_control seq_ctl_sva #(.NUM_SEG(NUM_SEG)) chk (.REF_CLK_I, .RST_B_I,
	.PSEL_I, .PENABLE_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .START_I, .ABORT_I,
	.STANDSTILL_I, .SEQ_CTRL_O, .STOP_REQ_O, .SEG_IDX_O);
`default_nettype wire

/* tb/motor_ctrl_model.sv */
/* motor control side: follows the run command, reaches standstill after a stop.
   assumes: one clock shared with the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_model #(parameter int STOP_CYC = 3) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic run_cmd_i,
	input wire logic stop_req_i,
	output logic motor_run_o,
	output logic standstill_o
);
	int cnt_r;
	// the drive coasts down, so standstill lags the stop request
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= 0;
			motor_run_o <= 1'b0;
		end else begin
			cnt_r <= stop_req_i ? ((cnt_r < STOP_CYC) ? cnt_r + 1 : cnt_r) : 0;
			motor_run_o <= run_cmd_i;
		end
	end
	assign standstill_o = (cnt_r == STOP_CYC);
endmodule
`default_nettype wire

/* tb/setpoint_sequencer_control_test.sv */
/* bench for the sequencer control: apb tasks, trigger pulses, motor model.
   assumes: seq_params.svh on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module setpoint_sequencer_control_test;
	logic clk, rst_b, psel, penable, pwrite, run_cmd, pready, pslverr;
	logic ctrl, stop, still, mrun, seen, rerr;
	logic [2:0] ctl;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] sp;
	logic [1:0] seg;
	int fail_count, comparisons, n, t_redo;
	logic [1:0] rst_exp [5] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2};
	logic [15:0] regs [3] = '{`IDX_STEP_MODE, `IDX_END_ACTION, `IDX_RESTART};
	setpoint_sequencer_control #(.NUM_SEG(4), .TICK_CYC(4)) dut (.REF_CLK_I(clk), .RST_B_I(rst_b),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.START_I(ctl[0]), .NEXT_STEP_I(ctl[1]), .ABORT_I(ctl[2]), .MOTOR_RUN_I(mrun),
		.STANDSTILL_I(still), .SETPOINT_O(sp), .SEQ_CTRL_O(ctrl), .STOP_REQ_O(stop),
		.SEG_IDX_O(seg));
	motor_ctrl_model mot (.clk_i(clk), .rst_b_i(rst_b), .run_cmd_i(run_cmd),
		.stop_req_i(stop), .motor_run_o(mrun), .standstill_o(still));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic give_verdict();
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one transfer; an idle cycle after it keeps psel from toggling twice in one step
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// bit 0 start, bit 1 next step, bit 2 abort
	task automatic pulse(input logic [2:0] m);
		ctl <= m;
		@(posedge clk);
		ctl <= 3'b000;
		@(posedge clk);
	endtask
	task automatic wait_seg(input logic [1:0] s);
		n = 0;
		while (seg !== s && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (seg !== s) begin
			fail_count++;
			give_verdict();
		end
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ctl, fail_count, comparisons} = '0;
		run_cmd = 1'b1;
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, regs[i], 32'h0);
			`CHK(rdat, 32'h0);
		end
		// disabled after reset: a start edge must not take control
		pulse(3'b001);
		`CHK(ctrl, 1'b0);
		apb(1'b0, 16'h4001, 32'h0);
		`CHK(rerr, 1'b1);
		apb(1'b1, `IDX_SEG_COUNT, 32'h3);
		apb(1'b1, `IDX_END_SETPOINT, 32'h0eee);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `IDX_DUR_BASE + 16'(i), 32'(i + 2));
			apb(1'b1, `IDX_SP_BASE + 16'(i), 32'h0a00 + 32'(i));
		end
		// trigger mode: the 8-cycle first segment time passes unheeded
		apb(1'b1, `IDX_STEP_MODE, 32'h2);
		pulse(3'b001);
		`CHK(sp, 16'h0a00);
		repeat (40) @(posedge clk);
		`CHK(seg, 2'd0);
		pulse(3'b010);
		`CHK(seg, 2'd1);
		pulse(3'b010);
		pulse(3'b010);
		repeat (20) @(posedge clk);
		`CHK(sp, 16'h0eee);
		`CHK(ctrl, 1'b1);
		pulse(3'b100);
		// time mode: trigger ignored, first segment lasts 8 cycles
		apb(1'b1, `IDX_STEP_MODE, 32'h1);
		pulse(3'b001);
		pulse(3'b010);
		`CHK(seg, 2'd0);
		wait_seg(2'd1);
		`CHK(n >= 5 && n <= 7, 1'b1);
		pulse(3'b100);
		// combined: early trigger, then the reloaded 12-cycle time
		apb(1'b1, `IDX_STEP_MODE, 32'h3);
		pulse(3'b001);
		repeat (3) @(posedge clk);
		pulse(3'b010);
		`CHK(sp, 16'h0a01);
		wait_seg(2'd2);
		`CHK(n >= 11 && n <= 13, 1'b1);
		apb(1'b1, `IDX_STEP_MODE, 32'h1);
		for (int a = 1; a < 4; a++) begin
			pulse(3'b100);
			apb(1'b1, `IDX_END_ACTION, 32'(a));
			apb(1'b0, `IDX_END_ACTION, 32'h0);
			`CHK(rdat, 32'(a));
			pulse(3'b001);
			seen = 1'b0;
			// whole sequence is 36 cycles, then the stop and standstill
			repeat (60) begin
				@(posedge clk);
				seen = seen | (stop === 1'b1);
			end
			`CHK(seen, a < 3);
			`CHK(ctrl, a == 1);
		end
		apb(1'b1, `IDX_END_ACTION, 32'h0);
		apb(1'b1, `IDX_STEP_MODE, 32'h3);
		// stop and restart in the second segment under each policy; combined mode
		// so that redo and continue differ in the time left in the segment
		for (int p = 0; p < 5; p++) begin
			pulse(3'b100);
			apb(1'b1, `IDX_RESTART, 32'(p));
			pulse(3'b001);
			pulse(3'b010);
			run_cmd <= 1'b0;
			repeat (3) @(posedge clk);
			if (p == 4)
				pulse(3'b010);
			run_cmd <= 1'b1;
			repeat (4) @(posedge clk);
			`CHK(seg, rst_exp[p]);
			if (p == 1 || p == 2)
				wait_seg(2'd2);
			if (p == 1)
				t_redo = n;
			// continuing keeps the time already run, so it ends before a redo
			if (p == 2)
				`CHK(n < t_redo, 1'b1);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
